// [design/tick_timer_pkg.sv]
// constants for the tick timer block
package tick_timer_pkg;
   localparam logic [11:0] CTRL_A_OFFS     = 12'h000;
   localparam logic [11:0] CTRL_B_OFFS     = 12'h004;
   localparam logic [11:0] COUNT_LO_OFFS   = 12'h008;
   localparam logic [11:0] COUNT_HI_OFFS   = 12'h00C;
   localparam logic [11:0] IRQ_OFFS        = 12'h010;
   localparam int          ON_BIT          = 7;
   localparam int          OUT_BIT         = 5;
   localparam int          WIDE_BIT        = 4;
   localparam int          POST_LSB        = 0;
   localparam int          SRC_LSB         = 5;
   localparam int          UNSYNC_BIT      = 4;
   localparam int          PRE_LSB         = 0;
   localparam int          IRQ_FLAG_BIT    = 0;
   localparam int          IRQ_EN_BIT      = 1;
   localparam logic [7:0]  CTRL_RESET      = 8'h00;
   localparam logic [7:0]  COUNT_LO_RESET  = 8'h00;
   localparam logic [7:0]  COUNT_HI_RESET  = 8'hFF;
   localparam logic [2:0]  SRC_LOGIC_CELL  = 3'h7;
   localparam logic [2:0]  SRC_SEC_OSC     = 3'h6;
   localparam logic [2:0]  SRC_MID_OSC     = 3'h5;
   localparam logic [2:0]  SRC_LOW_OSC     = 3'h4;
   localparam logic [2:0]  SRC_HIGH_OSC    = 3'h3;
   localparam logic [2:0]  SRC_INSTR       = 3'h2;
   localparam logic [2:0]  SRC_PIN_INV     = 3'h1;
   localparam logic [2:0]  SRC_PIN_TRUE    = 3'h0;
   localparam int          INSTR_DIV       = 4;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// [design/tick_timer.sv]
// timer with prescaler, postscaler, match/rollover flag and toggled output
// Operation
// [R1] postscaler divides events by field plus one
// [R2] postscaler cleared on low-byte or control_a write
// [R3] software computes period, no handler reload
// [R4] sleeping synchronised timer stops counting
// [R5] sleeping unsynchronised timer counts, may wake
// [R6] 8-bit match when low equals period
// [R7] 16-bit event on wrap to zero
// [R8] flag set every post_divide_sel+1 events
// [R9] enabled flag raises interrupt and wake
// [R10] output routable to pins and peripherals
// [R11] output level readable at control_a bit 5
// [R12] match_pulse one period per postscaled event
// [R13] output toggles on match_pulse rise
// [R14] timer_on enables, off means idle
// [R15] wide_mode_sel picks 16 or 8 bit
// [R16] tick_source_sel picks one of eight clocks
// [R17] unsynced_input_sel bypasses instruction-clock sync
// [R18] prescale two to power of field
// [R19] control_a bit 6 zero, controls reset zero
// [R20] match clears low, reloads period buffer
// [R21] 16-bit high byte buffered on read/write
// [R22] reset clears low, high becomes all ones
// [R23] software clears flag after service
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
module tick_timer
   import tick_timer_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // axi4-lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // tick sources, asynchronous to clk
   input  wire logic        ext_tick_pin,
   input  wire logic        logic_cell_one_out,
   input  wire logic        secondary_osc,
   input  wire logic        mid_freq_osc,
   input  wire logic        low_freq_osc,
   input  wire logic        high_freq_osc,
   // system
   input  wire logic        sleep_req,
   output logic             tick_out,
   output logic             match_pulse,
   output logic             irq,
   output logic             wake
);
   logic [1:0] rst_sync_r;
   wire        rst_n = rst_sync_r[1];
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rst_sync_r <= 2'b00;
      else rst_sync_r <= {rst_sync_r[0], 1'b1};
   end

   // registers
   logic       on_r, wide_r, unsync_r, irq_flag_r, irq_en_r, out_r;
   logic [3:0] post_sel_r, pre_sel_r, post_cnt_r;
   logic [2:0] src_sel_r;
   logic [7:0] lo_r, hi_r, hi_true_r, period_r;
   logic [14:0] pre_cnt_r;

   // source synchronisers; the second stage gives the current level, the third the previous level for edge detect
   logic [5:0] src_s1_r, src_s2_r, src_s3_r;
   wire  [5:0] src_raw = {logic_cell_one_out, secondary_osc, mid_freq_osc,
                          low_freq_osc, high_freq_osc, ext_tick_pin};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_s1_r <= 6'h00;
         src_s2_r <= 6'h00;
         src_s3_r <= 6'h00;
      end else begin
         src_s1_r <= src_raw;
         src_s2_r <= src_s1_r;
         src_s3_r <= src_s2_r;
      end
   end
   logic [1:0] sleep_s_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) sleep_s_r <= 2'b00;
      else sleep_s_r <= {sleep_s_r[0], sleep_req};
   end
   wire sleeping = sleep_s_r[1];

   // instruction clock enable: one pulse every INSTR_DIV cycles
   logic [1:0] instr_cnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) instr_cnt_r <= 2'h0;
      else instr_cnt_r <= instr_cnt_r + 2'h1;
   end
   wire instr_en = (instr_cnt_r == 2'(INSTR_DIV - 1));

   // source select [R16]
   function automatic logic pick_src(input logic [2:0] s, input logic [5:0] v);
      case (s)
         SRC_LOGIC_CELL: pick_src = v[5];
         SRC_SEC_OSC:    pick_src = v[4];
         SRC_MID_OSC:    pick_src = v[3];
         SRC_LOW_OSC:    pick_src = v[2];
         SRC_HIGH_OSC:   pick_src = v[1];
         SRC_PIN_INV:    pick_src = ~v[0];
         default:        pick_src = v[0];
      endcase
   endfunction
   wire src_now  = pick_src(src_sel_r, src_s2_r);
   wire src_prev = pick_src(src_sel_r, src_s3_r);
   wire is_instr = (src_sel_r == SRC_INSTR);
   wire src_rise = is_instr ? instr_en : (src_now & ~src_prev);

   // pending rising edge held until next instruction slot when synchronised [R17]
   logic pend_r;
   wire  raw_tick  = unsync_r ? src_rise : ((pend_r | src_rise) & instr_en);
   // sleeping synchronised timer halts [R4]; async keeps counting [R5]
   wire  run       = on_r & ~(sleeping & ~unsync_r);            // [R14] [R4] [R5]
   wire  tick_in   = run & raw_tick;

   // prescaler 2^n [R18]
   wire [14:0] pre_mask = 15'((16'h0001 << pre_sel_r) - 16'h0001);
   wire        pre_done = ((pre_cnt_r & pre_mask) == pre_mask);
   wire        cnt_en   = tick_in & pre_done;

   // count logic [R6] [R7] [R20]
   wire        match8   = ~wide_r & (lo_r == period_r);         // [R6]
   wire        wrap16   = wide_r & (hi_true_r == 8'hFF) & (lo_r == 8'hFF); // [R7]
   wire        event_hit = cnt_en & (match8 | wrap16);
   wire        post_done = (post_cnt_r == post_sel_r);          // [R1]
   wire        flag_set  = event_hit & post_done;               // [R8]

   // bus decode
   logic       aw_hold_r, w_hold_r;
   logic [11:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   wire         wr_go   = aw_hold_r & w_hold_r & ~s_axi_bvalid;
   wire         wr_lane = w_strb_r[0];
   wire         wr_a    = wr_go & wr_lane & (aw_addr_r == CTRL_A_OFFS);
   wire         wr_b    = wr_go & wr_lane & (aw_addr_r == CTRL_B_OFFS);
   wire         wr_lo   = wr_go & wr_lane & (aw_addr_r == COUNT_LO_OFFS);
   wire         wr_hi   = wr_go & wr_lane & (aw_addr_r == COUNT_HI_OFFS);
   wire         wr_irq  = wr_go & wr_lane & (aw_addr_r == IRQ_OFFS);
   wire         wr_hit  = (aw_addr_r == CTRL_A_OFFS) | (aw_addr_r == CTRL_B_OFFS) |
                          (aw_addr_r == COUNT_LO_OFFS) | (aw_addr_r == COUNT_HI_OFFS) |
                          (aw_addr_r == IRQ_OFFS);
   wire  [7:0]  wb      = w_data_r[7:0];
   wire         rd_go   = s_axi_arvalid & s_axi_arready;
   wire         rd_lo   = rd_go & (s_axi_araddr == COUNT_LO_OFFS);
   wire         clr_scal = wr_lo | wr_a | wr_b;                 // [R2]

   // control registers [R14] [R15] [R19]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_r <= 1'b0;
         wide_r <= 1'b0;
         post_sel_r <= CTRL_RESET[3:0];
         src_sel_r <= CTRL_RESET[7:5];
         unsync_r <= 1'b0;
         pre_sel_r <= CTRL_RESET[3:0];
         irq_en_r <= 1'b0;
      end else begin
         if (wr_a) begin
            on_r <= wb[ON_BIT];
            wide_r <= wb[WIDE_BIT];
            post_sel_r <= wb[POST_LSB +: 4];
         end
         if (wr_b) begin
            src_sel_r <= wb[SRC_LSB +: 3];
            unsync_r <= wb[UNSYNC_BIT];
            pre_sel_r <= wb[PRE_LSB +: 4];
         end
         if (wr_irq) irq_en_r <= wb[IRQ_EN_BIT];
      end
   end

   // prescaler/postscaler/pending [R1] [R2]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_cnt_r <= 15'h0000;
         post_cnt_r <= 4'h0;
         pend_r <= 1'b0;
      end else begin
         pend_r <= unsync_r ? 1'b0 : ((pend_r | src_rise) & ~instr_en);
         if (clr_scal) begin
            pre_cnt_r <= 15'h0000;
            post_cnt_r <= 4'h0;                                 // [R2]
         end else begin
            if (tick_in) pre_cnt_r <= pre_done ? 15'h0000 : pre_cnt_r + 15'h0001;
            if (event_hit) post_cnt_r <= post_done ? 4'h0 : post_cnt_r + 4'h1; // [R1]
         end
      end
   end

   // count registers [R20] [R21] [R22]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lo_r <= COUNT_LO_RESET;                                // [R22]
         hi_r <= COUNT_HI_RESET;                                // [R22]
         hi_true_r <= 8'h00;
         period_r <= COUNT_HI_RESET;
      end else begin
         if (wr_hi) hi_r <= wb;
         else if (rd_lo & wide_r) hi_r <= hi_true_r;            // [R21]
         if (wr_lo) begin
            lo_r <= wb;
            if (wide_r) hi_true_r <= hi_r;                      // [R21]
         end else if (cnt_en) begin
            if (match8) begin
               lo_r <= 8'h00;                                   // [R20]
               period_r <= hi_r;                                // [R20]
            end else begin
               lo_r <= lo_r + 8'h01;
               if (wide_r & (lo_r == 8'hFF)) hi_true_r <= hi_true_r + 8'h01; // [R7]
            end
         end
      end
   end

   // flag, output, pulse [R8] [R9] [R12] [R13]
   logic pulse_hold_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_flag_r <= 1'b0;
         out_r <= 1'b0;
         match_pulse <= 1'b0;
         pulse_hold_r <= 1'b0;
         tick_out <= 1'b0;
         irq <= 1'b0;
         wake <= 1'b0;
      end else begin
         // set beats software clear [R8] [R23]
         if (flag_set) irq_flag_r <= 1'b1;
         else if (wr_irq & ~wb[IRQ_FLAG_BIT]) irq_flag_r <= 1'b0;
         // pulse spans one prescaled period [R12]
         if (flag_set) pulse_hold_r <= 1'b1;
         else if (cnt_en | clr_scal | ~on_r) pulse_hold_r <= 1'b0;
         match_pulse <= flag_set | (pulse_hold_r & ~(cnt_en | clr_scal | ~on_r));
         if (flag_set) out_r <= ~out_r;                         // [R13]
         tick_out <= flag_set ? ~out_r : out_r;                 // [R10]
         irq <= irq_en_r & (irq_flag_r | flag_set);             // [R9]
         wake <= irq_en_r & (irq_flag_r | flag_set) & sleeping; // [R9] [R5]
      end
   end

   // axi4-lite write channel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_addr_r <= 12'h000;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_hold_r & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_hold_r & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // axi4-lite read channel; control_a bit 6 reads zero [R11] [R19]
   wire [7:0] ctrl_a_rd = {on_r, 1'b0, out_r, wide_r, post_sel_r};  // [R11] [R19]
   wire [7:0] ctrl_b_rd = {src_sel_r, unsync_r, pre_sel_r};
   wire [7:0] irq_rd    = {6'h00, irq_en_r, irq_flag_r};
   wire [11:0] ra       = {s_axi_araddr[11:2], 2'b00};
   wire        rd_hit   = (ra == CTRL_A_OFFS) | (ra == CTRL_B_OFFS) |
                          (ra == COUNT_LO_OFFS) | (ra == COUNT_HI_OFFS) | (ra == IRQ_OFFS);
   wire [7:0]  rd_byte  = (ra == CTRL_A_OFFS)   ? ctrl_a_rd :
                          (ra == CTRL_B_OFFS)   ? ctrl_b_rd :
                          (ra == COUNT_LO_OFFS) ? lo_r :
                          (ra == COUNT_HI_OFFS) ? hi_r :
                          (ra == IRQ_OFFS)      ? irq_rd : 8'h00;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks
   chk_post_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R2]
      clr_scal |=> (post_cnt_r == 4'h0))
      else $error("postscaler not cleared");
   chk_flag_ratio: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      (event_hit & ~clr_scal & (post_cnt_r != post_sel_r)) |=> !$rose(irq_flag_r))
      else $error("flag set early");
   chk_flag_set: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
      flag_set |=> irq_flag_r)
      else $error("flag not set");
   chk_sync_sleep: assert property (@(posedge clk) disable iff (!rst_n) // [R4]
      (sleeping & ~unsync_r) |-> !cnt_en)
      else $error("counting in sync sleep");
   chk_off_idle: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
      !on_r |-> !cnt_en)
      else $error("counting while off");
   chk_out_toggle: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
      flag_set |=> (out_r != $past(out_r)))
      else $error("output not toggled");
   chk_match_clear: assert property (@(posedge clk) disable iff (!rst_n) // [R20]
      (cnt_en & match8 & ~wr_lo) |=> (lo_r == 8'h00))
      else $error("match did not clear low");
   chk_irq_out: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
      (irq_en_r & irq_flag_r) |=> irq)
      else $error("irq missing");
   chk_wrap_evt: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
      (cnt_en & wrap16 & ~wr_lo) |=> (lo_r == 8'h00 && hi_true_r == 8'h00))
      else $error("wrap wrong");
   chk_bit6_zero: assert property (@(posedge clk) disable iff (!rst_n) // [R19]
      ctrl_a_rd[6] == 1'b0)
      else $error("bit 6 set");
   chk_wide_load: assert property (@(posedge clk) disable iff (!rst_n) // [R21]
      (wr_lo & wide_r) |=> (hi_true_r == $past(hi_r)))
      else $error("high byte not loaded");
   chk_pulse_follow: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
      flag_set |=> match_pulse)
      else $error("match pulse missing");
   chk_async_run: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
      (on_r & unsync_r & sleeping & src_rise) |-> tick_in)
      else $error("async sleep not counting");
   cov_match8: cover property (@(posedge clk) disable iff (!rst_n) cnt_en & match8);
   cov_async: cover property (@(posedge clk) disable iff (!rst_n)
      sleeping & unsync_r & cnt_en);
   cov_wrap16: cover property (@(posedge clk) disable iff (!rst_n) cnt_en & wrap16);
   cov_post16: cover property (@(posedge clk) disable iff (!rst_n)
      flag_set & (post_sel_r == 4'hF));
   cov_wake: cover property (@(posedge clk) disable iff (!rst_n) wake);
endmodule // tick_timer

// [verification/test_tick_timer.sv]
// self-checking bench for the tick timer block
`timescale 1ns/10ps
module test_tick_timer;
   import tick_timer_pkg::*;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_req = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        tick_out, match_pulse, irq, wake;
   logic [5:0]  src_v = 6'h15;
   logic [2:0]  src_div = 3'h0;
   logic [31:0] seed = 32'd36;
   int          n_errors = 0;
   int          comparisons = 0;
   int          cyc = 0;

   always #5 clk = ~clk;

   // all tick sources toggle every eight clocks
   always @(posedge clk) begin
      cyc <= cyc + 1;
      src_div <= src_div + 3'h1;
      if (src_div == 3'h7) begin
         src_v <= ~src_v;
      end
   end

   tick_timer u_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .ext_tick_pin(src_v[0]), .logic_cell_one_out(src_v[1]), .secondary_osc(src_v[2]),
      .mid_freq_osc(src_v[3]), .low_freq_osc(src_v[4]), .high_freq_osc(src_v[5]),
      .sleep_req, .tick_out, .match_pulse, .irq, .wake);

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int exp_gap(int post, int per, int pre);
      return (post + 1) * (per + 1) * 4 * (1 << pre);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      $display("mismatches %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      int k;
      k = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && k < 50);
      s_axi_bready <= 1'b0;
      chk({31'h0, s_axi_bvalid}, 32'h1);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
      int k;
      k = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         k++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && k < 50);
      v = s_axi_rdata;
      r = s_axi_rresp;
      chk({31'h0, s_axi_rvalid}, 32'h1);
      s_axi_rready <= 1'b0;
   endtask

   task automatic wait_pulse(input int lim, output int t);
      int k;
      k = 0;
      while (match_pulse === 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
      while (match_pulse !== 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
      t = cyc;
      chk({31'h0, match_pulse}, 32'h1);
   endtask

   initial begin
      #600_000;
      n_errors++;
      results();
   end

   initial begin
      logic [11:0] offs [5];
      logic [7:0]  rv [5];
      logic [31:0] d, d0;
      logic [1:0]  r;
      logic        o0;
      int          t0, t1, post, per, pre;
      offs = '{CTRL_A_OFFS, CTRL_B_OFFS, COUNT_LO_OFFS, COUNT_HI_OFFS, IRQ_OFFS};
      rv = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         rd(offs[i], d, r);
         chk(d, {24'h0, rv[i]});
      end
      rd(12'h020, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      wr(CTRL_A_OFFS, 8'h6F);
      rd(CTRL_A_OFFS, d, r);
      chk(d, 32'h0000000F);
      d0 = xs() & 32'h000000FF;
      wr(CTRL_B_OFFS, d0[7:0]);
      rd(CTRL_B_OFFS, d, r);
      chk(d, d0);
      s_axi_wstrb <= 4'hE;
      wr(CTRL_B_OFFS, 8'hFF);
      s_axi_wstrb <= 4'hF;
      rd(CTRL_B_OFFS, d, r);
      chk(d, d0);
      wr(COUNT_HI_OFFS, 8'hFF);
      wr(CTRL_A_OFFS, 8'h80);
      for (int s = 0; s < 8; s++) begin
         wr(CTRL_B_OFFS, {3'(s), 5'h00});
         wr(COUNT_LO_OFFS, 8'h00);
         repeat (200) @(posedge clk);
         rd(COUNT_LO_OFFS, d, r);
         chk({31'h0, d[7:0] != 8'h00}, 32'h1);
      end
      wr(CTRL_A_OFFS, 8'h00);
      wr(COUNT_LO_OFFS, 8'h05);
      repeat (100) @(posedge clk);
      rd(COUNT_LO_OFFS, d, r);
      chk(d, 32'h5);
      wr(IRQ_OFFS, 8'h02);
      for (int i = 0; i < 4; i++) begin
         post = (i == 0) ? 0 : (i == 3) ? 15 : int'(xs() % 32'd16);
         per = 1 + int'(xs() % 32'd7);
         pre = int'(xs() % 32'd2);
         wr(COUNT_HI_OFFS, 8'(per));
         wr(CTRL_B_OFFS, {SRC_INSTR, 1'b0, 4'(pre)});
         wr(CTRL_A_OFFS, {4'h8, 4'(post)});
         wr(COUNT_LO_OFFS, 8'h00);
         wait_pulse(8000, t0);
         repeat (2) @(posedge clk);
         o0 = tick_out;
         wait_pulse(4000, t1);
         repeat (2) @(posedge clk);
         chk(t1 - t0, exp_gap(post, per, pre));
         chk({31'h0, tick_out}, {31'h0, ~o0});
         chk({30'h0, irq, wake}, 32'h2);
         wr(CTRL_A_OFFS, 8'h00);
         rd(CTRL_A_OFFS, d, r);
         chk({31'h0, d[OUT_BIT]}, {31'h0, tick_out});
         rd(IRQ_OFFS, d, r);
         chk(d, 32'h3);
         wr(IRQ_OFFS, 8'h02);
         repeat (3) @(posedge clk);
         chk({31'h0, irq}, 32'h0);
      end
      wr(COUNT_HI_OFFS, 8'hFF);
      wr(CTRL_B_OFFS, {SRC_INSTR, 5'h00});
      wr(CTRL_A_OFFS, 8'h80);
      sleep_req <= 1'b1;
      repeat (10) @(posedge clk);
      rd(COUNT_LO_OFFS, d0, r);
      repeat (100) @(posedge clk);
      rd(COUNT_LO_OFFS, d, r);
      chk(d, d0);
      wr(IRQ_OFFS, 8'h02);
      repeat (2) @(posedge clk);
      chk({30'h0, wake, irq}, 32'h0);
      wr(CTRL_B_OFFS, {SRC_SEC_OSC, 5'h10});
      t0 = 0;
      while (wake !== 1'b1 && t0 < 6000) begin
         @(posedge clk);
         t0++;
      end
      chk({30'h0, wake, irq}, 32'h3);
      sleep_req <= 1'b0;
      repeat (6) @(posedge clk);
      chk({31'h0, wake}, 32'h0);
      wr(CTRL_A_OFFS, 8'h10);
      wr(IRQ_OFFS, 8'h02);
      wr(CTRL_B_OFFS, {SRC_INSTR, 5'h00});
      wr(COUNT_HI_OFFS, 8'hFF);
      wr(COUNT_LO_OFFS, 8'hF0);
      wr(COUNT_HI_OFFS, 8'h3C);
      rd(COUNT_LO_OFFS, d, r);
      chk(d, 32'hF0);
      rd(COUNT_HI_OFFS, d, r);
      chk(d, 32'hFF);
      wr(CTRL_A_OFFS, 8'h90);
      wait_pulse(200, t0);
      rd(COUNT_LO_OFFS, d, r);
      rd(COUNT_HI_OFFS, d, r);
      chk(d, 32'h00);
      results();
   end
endmodule // test_tick_timer
